//--- ttrb_regs.svh
// Purpose: Offsets, field positions and reset values of the transceiver test register bank.
// Assumes: Byte-wide registers addressed by the serial control interface.
// Notes: Definitions only.
`ifndef TTRB_REGS_SVH
`define TTRB_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TTRB_OFS_TEST_SIGNAL_SELECT 8'h35
`define TTRB_OFS_ANALOG_TEST 8'h36
`define TTRB_OFS_REGULATOR_OVERRIDE 8'h37
`define TTRB_OFS_BLOCK_FORCE_ENABLE 8'h38
`define TTRB_OFS_RC_CAL_CONTROL 8'h39
`define TTRB_OFS_OSC_BIAS_TEST 8'h3A
`define TTRB_NUM_REGS 6
`define TTRB_IDX_W 3

// ----------------------------------------------------------------------------
// Reset values (every test bit clears at power-up)
// ----------------------------------------------------------------------------
`define TTRB_RST_BYTE 8'h00
`define TTRB_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
// Test signal select.
`define TTRB_B_MULTITONE 7
`define TTRB_F_DIG_PROBE 6:4
`define TTRB_F_RX_DEBUG 3:0
// Analog test and PLL configuration.
`define TTRB_B_IF_LOW_SUPPLY 7
`define TTRB_F_ANA_PROBE 6:4
`define TTRB_B_DIG_REG_DIS 3
`define TTRB_F_PLL_CONFIG 2:1
`define TTRB_B_OSC_CORE_TEST 0
// Regulator and status override.
`define TTRB_B_VCO_REG_FORCE 7
`define TTRB_B_PLL_REG_FORCE 6
`define TTRB_B_AMP_REG_FORCE 5
`define TTRB_B_VCO_RDY_OVR 4
`define TTRB_B_PLL_RDY_OVR 3
`define TTRB_B_AMP_RDY_OVR 2
`define TTRB_B_LOCK_OVR 1
`define TTRB_B_XTAL_RDY_OVR 0
// Block force enable: bits 7..1 are the seven blocks, bit 0 the step bypass.
`define TTRB_F_BLOCKS 7:1
`define TTRB_B_AMP_STEP_BYPASS 0
// RC calibration control.
`define TTRB_B_CAL_TRIGGER 7
`define TTRB_B_CAL_SUPPRESS 6
`define TTRB_F_CAL_ADJUST 5:4
`define TTRB_F_CAL_MANUAL 3:0
// Oscillator bias test.
`define TTRB_F_XO_OFFSET_LEVEL 7:5
`define TTRB_B_XO_SINK 4
`define TTRB_B_XO_OFFSET_EN 3
`define TTRB_B_CRYSTAL_STARTUP_KICK_DISABLE 2
`define TTRB_B_CRYSTAL_DETECTOR_DISABLE 1
`define TTRB_B_CRYSTAL_BIAS_DISABLE 0

`endif

//--- ttrb_pkg.sv
// Purpose: Types shared by the test register bank modules.
// Assumes: Constants come from ttrb_regs.svh.
// Notes: Types only.
package ttrb_pkg;
	typedef logic [7:0] ttrb_byte_t;
	typedef logic [2:0] ttrb_idx_t;
	typedef logic [3:0] ttrb_cal_val_t;
	typedef enum logic [0:0] {TTRB_CAL_IDLE, TTRB_CAL_RUN} ttrb_cal_state_t;
endpackage : ttrb_pkg

//--- ttrb_cal_if.sv
// Purpose: Bundle between the register bank and its RC calibration control.
// Assumes: One clock domain.
// Notes: The bank drives the settings, the control returns result and busy.
`timescale 1ns/1ps
interface ttrb_cal_if;
	import ttrb_pkg::*;
	logic trigger;
	logic suppress;
	ttrb_cal_val_t manual;
	ttrb_cal_val_t result;
	logic busy;
	modport bank (output trigger, output suppress, output manual, input result, input busy);
	modport cal (input trigger, input suppress, input manual, output result, output busy);
endinterface : ttrb_cal_if

//--- ttrb_rc_cal_ctrl.sv
// Purpose: Start, suppress and result handling of the channel-filter RC calibration.
// Assumes: The calibration engine answers a start pulse with a done pulse.
// Notes: The result field holds the engine value or the manual value.
`timescale 1ns/1ps
`include "ttrb_regs.svh"
module ttrb_rc_cal_ctrl
	import ttrb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	ttrb_cal_if.cal cif,
	output logic cal_start,
	input wire logic cal_done,
	input wire ttrb_cal_val_t cal_auto_value
);
	logic trig_prev_q;
	logic start_q;
	ttrb_cal_state_t state_q;
	ttrb_cal_val_t result_q;

	// ------------------------------------------------------------------------
	// Start request
	// ------------------------------------------------------------------------
	// A rising trigger bit issues one start; a level would restart forever.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			trig_prev_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			trig_prev_q <= cif.trigger;
			start_q <= cif.trigger && !trig_prev_q && !cif.suppress && (state_q == TTRB_CAL_IDLE); // R5
		end
	end
	assign cal_start = start_q;

	// Busy tracking, so that a second trigger during a run is ignored and does not restart the engine.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= TTRB_CAL_IDLE;
		end else begin
			case (state_q)
				TTRB_CAL_IDLE: if (start_q) state_q <= TTRB_CAL_RUN;
				TTRB_CAL_RUN: if (cal_done) state_q <= TTRB_CAL_IDLE;
				default: state_q <= TTRB_CAL_IDLE;
			endcase
		end
	end
	assign cif.busy = (state_q == TTRB_CAL_RUN);

	// ------------------------------------------------------------------------
	// Result field
	// ------------------------------------------------------------------------
	// With suppression the manual value stands in the result field.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			result_q <= 4'h0;
		end else if (cif.suppress) begin
			result_q <= cif.manual; // R7
		end else if (cal_done && state_q == TTRB_CAL_RUN) begin
			result_q <= cal_auto_value;
		end
	end
	assign cif.result = result_q;

	// Assertions.
	a_cal_start_edge: assert property (@(posedge clk) disable iff (!rst_b)
		cal_start |-> $past(cif.trigger) && !$past(trig_prev_q) && !$past(cif.suppress)) // R5
		else $error("calibration start without a trigger edge");
	a_cal_suppress_blocks: assert property (@(posedge clk) disable iff (!rst_b)
		cif.suppress |=> !cal_start) // R5
		else $error("calibration started while suppressed");
	a_manual_result: assert property (@(posedge clk) disable iff (!rst_b)
		cif.suppress |=> cif.result == $past(cif.manual)) // R7
		else $error("manual calibration value not used");
	c_cal_run: cover property (@(posedge clk) disable iff (!rst_b) cal_start ##[1:50] cal_done);
endmodule : ttrb_rc_cal_ctrl

//--- ttrb_test_register_bank.sv
// Purpose: Six byte-wide test registers of the transceiver and the overrides they drive.
// Assumes: The serial interface presents completed writes and read requests as
//   single-cycle strobes on clk; status and normal control inputs are on clk.
// Notes: Unmapped reads return zero; unmapped writes are dropped.
// Function
// R1: Ready and lock overrides force status good.
// R2: Regulator force bits switch VCO, PLL, amplifier.
// R3: Block enable bits 7..1 enable seven blocks.
// R4: Bit 0 bypasses amplifier step decoder.
// R5: Calibration trigger and suppress bits.
// R6: Adjust field shifts calibration reference.
// R7: Manual value feeds calibration result field.
// R8: Offset sink acts only with offset enabled.
// R9: Software keeps crystal test bits off normally.
// R10: Software sets low-supply bit below 2.0 V.
// R11: Bit 3 disables digital regulator.
// R12: Digital probe select feeds pin multiplexers.
// R13: Bit 7 enables filter multi-tone test.
// R14: Bits 7:5 set oscillator offset current.
// R15: Bit 0 disables crystal bias circuit.
// R16: All bits clear at reset.
// R17: Switch mode picks OR or replace.
// R18: Byte registers, read-write, effective after write.
`timescale 1ns/1ps
`include "ttrb_regs.svh"
module ttrb_test_register_bank
	import ttrb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	// Register port from the serial control interface.
	input wire logic reg_wr_en,
	input wire ttrb_byte_t reg_wr_addr,
	input wire ttrb_byte_t reg_wr_data,
	input wire logic reg_rd_en,
	input wire ttrb_byte_t reg_rd_addr,
	output ttrb_byte_t reg_rd_data,
	// Regulator control.
	input wire logic regulator_switch_mode,
	input wire logic vco_regulator_normal,
	input wire logic pll_regulator_normal,
	input wire logic amp_regulator_normal,
	output logic vco_regulator_on,
	output logic pll_regulator_on,
	output logic amp_regulator_on,
	// Block status, raw and as seen by the start-up sequencers.
	input wire logic vco_regulator_ready_raw,
	input wire logic pll_regulator_ready_raw,
	input wire logic amp_regulator_ready_raw,
	input wire logic pll_lock_raw,
	input wire logic crystal_ready_raw,
	output logic vco_regulator_ready,
	output logic pll_regulator_ready,
	output logic amp_regulator_ready,
	output logic pll_lock,
	output logic crystal_ready,
	// Test signal routing.
	output logic filter_multitone_enable,
	output logic [2:0] digital_probe_select,
	output logic [3:0] receive_debug_select,
	output logic if_buffer_low_supply,
	output logic [2:0] analog_probe_select,
	output logic digital_regulator_disable,
	output logic [1:0] pll_test_config,
	output logic oscillator_core_test_enable,
	// Block force enables.
	output logic vco_block_enable,
	output logic prescaler_enable,
	output logic phase_detector_enable,
	output logic pll_clock_enable,
	output logic amp_block_enable,
	output logic bandgap_enable,
	output logic receiver_enable,
	output logic amp_step_bypass_test,
	// Channel-filter RC calibration.
	output logic rc_cal_start,
	input wire logic rc_cal_done,
	input wire ttrb_cal_val_t rc_cal_auto_value,
	output logic [1:0] rc_cal_reference_adjust,
	output ttrb_cal_val_t rc_cal_result,
	output logic rc_cal_busy,
	// Crystal oscillator test.
	output logic [2:0] crystal_offset_current_level,
	output logic crystal_offset_sink_select,
	output logic crystal_offset_enable,
	output logic crystal_startup_kick_disable,
	output logic crystal_detector_disable,
	output logic crystal_bias_disable
);

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	// Maps a byte address to a register index; hit is low outside the bank.
	function automatic logic ttrb_decode(input ttrb_byte_t addr, output ttrb_idx_t idx);
		idx = 3'd0;
		if (addr == `TTRB_OFS_TEST_SIGNAL_SELECT) begin
			idx = 3'd0;
		end else if (addr == `TTRB_OFS_ANALOG_TEST) begin
			idx = 3'd1;
		end else if (addr == `TTRB_OFS_REGULATOR_OVERRIDE) begin
			idx = 3'd2;
		end else if (addr == `TTRB_OFS_BLOCK_FORCE_ENABLE) begin
			idx = 3'd3;
		end else if (addr == `TTRB_OFS_RC_CAL_CONTROL) begin
			idx = 3'd4;
		end else if (addr == `TTRB_OFS_OSC_BIAS_TEST) begin
			idx = 3'd5;
		end else begin
			return 1'b0;
		end
		return 1'b1;
	endfunction : ttrb_decode

	localparam ttrb_idx_t IDX_SIG = 3'd0;
	localparam ttrb_idx_t IDX_ANA = 3'd1;
	localparam ttrb_idx_t IDX_REG = 3'd2;
	localparam ttrb_idx_t IDX_BLK = 3'd3;
	localparam ttrb_idx_t IDX_CAL = 3'd4;
	localparam ttrb_idx_t IDX_XO = 3'd5;

	ttrb_byte_t regs_q [`TTRB_NUM_REGS];
	ttrb_byte_t rd_data_q;
	ttrb_idx_t wr_idx;
	ttrb_idx_t rd_idx;
	logic wr_hit;
	logic rd_hit;

	always_comb begin
		wr_hit = ttrb_decode(reg_wr_addr, wr_idx);
		rd_hit = ttrb_decode(reg_rd_addr, rd_idx);
	end

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	// A completed serial write lands on the next edge and acts from then on.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < `TTRB_NUM_REGS; i++) begin
				regs_q[i] <= `TTRB_RST_BYTE; // R16
			end
		end else if (reg_wr_en && wr_hit) begin
			regs_q[wr_idx] <= reg_wr_data; // R18
		end
	end

	// Read data is registered; the calibration result shows in place of the
	// manual nibble so software sees the value actually in use.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_data_q <= `TTRB_RD_UNMAPPED;
		end else if (reg_rd_en) begin
			if (!rd_hit) begin
				rd_data_q <= `TTRB_RD_UNMAPPED;
			end else if (rd_idx == IDX_CAL) begin
				rd_data_q <= {regs_q[IDX_CAL][7:4], rc_cal_result}; // R18
			end else begin
				rd_data_q <= regs_q[rd_idx]; // R18
			end
		end
	end
	assign reg_rd_data = rd_data_q;

	// ------------------------------------------------------------------------
	// Test signal routing
	// ------------------------------------------------------------------------
	assign filter_multitone_enable = regs_q[IDX_SIG][`TTRB_B_MULTITONE]; // R13
	assign digital_probe_select = regs_q[IDX_SIG][`TTRB_F_DIG_PROBE]; // R12
	assign receive_debug_select = regs_q[IDX_SIG][`TTRB_F_RX_DEBUG];
	// The low-supply bit is only steered; choosing it is up to software.
	assign if_buffer_low_supply = regs_q[IDX_ANA][`TTRB_B_IF_LOW_SUPPLY]; // R10
	assign analog_probe_select = regs_q[IDX_ANA][`TTRB_F_ANA_PROBE];
	assign digital_regulator_disable = regs_q[IDX_ANA][`TTRB_B_DIG_REG_DIS]; // R11
	assign pll_test_config = regs_q[IDX_ANA][`TTRB_F_PLL_CONFIG];
	assign oscillator_core_test_enable = regs_q[IDX_ANA][`TTRB_B_OSC_CORE_TEST];

	// ------------------------------------------------------------------------
	// Regulators and status overrides
	// ------------------------------------------------------------------------
	// OR mode can only add turn-on; replace mode also allows forcing off.
	function automatic logic ttrb_reg_ctrl(input logic mode, input logic normal, input logic force_on);
		return mode ? force_on : (normal | force_on);
	endfunction : ttrb_reg_ctrl

	assign vco_regulator_on = ttrb_reg_ctrl(regulator_switch_mode, vco_regulator_normal,
		regs_q[IDX_REG][`TTRB_B_VCO_REG_FORCE]); // R2 R17
	assign pll_regulator_on = ttrb_reg_ctrl(regulator_switch_mode, pll_regulator_normal,
		regs_q[IDX_REG][`TTRB_B_PLL_REG_FORCE]); // R2 R17
	assign amp_regulator_on = ttrb_reg_ctrl(regulator_switch_mode, amp_regulator_normal,
		regs_q[IDX_REG][`TTRB_B_AMP_REG_FORCE]); // R2 R17

	// An override masks a failing block so sequencers keep going.
	assign vco_regulator_ready = vco_regulator_ready_raw | regs_q[IDX_REG][`TTRB_B_VCO_RDY_OVR]; // R1
	assign pll_regulator_ready = pll_regulator_ready_raw | regs_q[IDX_REG][`TTRB_B_PLL_RDY_OVR]; // R1
	assign amp_regulator_ready = amp_regulator_ready_raw | regs_q[IDX_REG][`TTRB_B_AMP_RDY_OVR]; // R1
	assign pll_lock = pll_lock_raw | regs_q[IDX_REG][`TTRB_B_LOCK_OVR]; // R1
	assign crystal_ready = crystal_ready_raw | regs_q[IDX_REG][`TTRB_B_XTAL_RDY_OVR]; // R1

	// ------------------------------------------------------------------------
	// Block force enables
	// ------------------------------------------------------------------------
	// Receive needs the bandgap as well; software sets both.
	assign {vco_block_enable, prescaler_enable, phase_detector_enable, pll_clock_enable,
		amp_block_enable, bandgap_enable, receiver_enable} = regs_q[IDX_BLK][`TTRB_F_BLOCKS]; // R3
	assign amp_step_bypass_test = regs_q[IDX_BLK][`TTRB_B_AMP_STEP_BYPASS]; // R4

	// ------------------------------------------------------------------------
	// RC calibration
	// ------------------------------------------------------------------------
	// Adjust code 00/01/10/11 shifts the reference by 0, +12.5, -6.2, -4.1 percent.
	assign rc_cal_reference_adjust = regs_q[IDX_CAL][`TTRB_F_CAL_ADJUST]; // R6

	ttrb_cal_if cal_bus ();
	assign cal_bus.trigger = regs_q[IDX_CAL][`TTRB_B_CAL_TRIGGER]; // R5
	assign cal_bus.suppress = regs_q[IDX_CAL][`TTRB_B_CAL_SUPPRESS]; // R5
	assign cal_bus.manual = regs_q[IDX_CAL][`TTRB_F_CAL_MANUAL]; // R7
	assign rc_cal_result = cal_bus.result;
	assign rc_cal_busy = cal_bus.busy;

	ttrb_rc_cal_ctrl u_rc_cal (
		.clk(clk),
		.rst_b(rst_b),
		.cif(cal_bus),
		.cal_start(rc_cal_start),
		.cal_done(rc_cal_done),
		.cal_auto_value(rc_cal_auto_value)
	);

	// ------------------------------------------------------------------------
	// Crystal oscillator test
	// ------------------------------------------------------------------------
	// These bits must stay clear in normal operation; nothing here enforces it.
	assign crystal_offset_current_level = regs_q[IDX_XO][`TTRB_F_XO_OFFSET_LEVEL]; // R14
	assign crystal_offset_enable = regs_q[IDX_XO][`TTRB_B_XO_OFFSET_EN]; // R9
	// Sink direction is meaningless without the offset, so it is gated off.
	assign crystal_offset_sink_select = regs_q[IDX_XO][`TTRB_B_XO_SINK] & regs_q[IDX_XO][`TTRB_B_XO_OFFSET_EN]; // R8
	assign crystal_startup_kick_disable = regs_q[IDX_XO][`TTRB_B_CRYSTAL_STARTUP_KICK_DISABLE];
	assign crystal_detector_disable = regs_q[IDX_XO][`TTRB_B_CRYSTAL_DETECTOR_DISABLE];
	assign crystal_bias_disable = regs_q[IDX_XO][`TTRB_B_CRYSTAL_BIAS_DISABLE]; // R15

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	// Checks look one edge after a strobe, because writes and reads both land on that edge.
	a_write_takes_effect: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr_en && reg_wr_addr == `TTRB_OFS_OSC_BIAS_TEST |=>
		crystal_bias_disable == $past(reg_wr_data[0]) &&
		crystal_offset_current_level == $past(reg_wr_data[7:5])) // R18
		else $error("oscillator test write not in effect next cycle");

	// A write in the same cycle may change the register, so the old contents are expected.
	a_read_returns_reg: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd_en && reg_rd_addr == `TTRB_OFS_BLOCK_FORCE_ENABLE |=>
		reg_rd_data == $past(regs_q[IDX_BLK])) // R18
		else $error("block enable readback mismatch");

	a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd_en && (reg_rd_addr < `TTRB_OFS_TEST_SIGNAL_SELECT || reg_rd_addr > `TTRB_OFS_OSC_BIAS_TEST)
		|=> reg_rd_data == 8'h00) // R18
		else $error("unmapped read not zero");

	a_reset_clears: assert property (@(posedge clk)
		!rst_b |=> !filter_multitone_enable && !vco_block_enable && !crystal_bias_disable &&
		digital_probe_select == 3'h0 && !digital_regulator_disable) // R16
		else $error("test bits not cleared by reset");

	a_lock_override: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr_en && reg_wr_addr == `TTRB_OFS_REGULATOR_OVERRIDE && reg_wr_data[1] |=> pll_lock) // R1
		else $error("lock override not forcing lock good");

	a_regulator_replace: assert property (@(posedge clk) disable iff (!rst_b)
		regulator_switch_mode && !regs_q[IDX_REG][7] |-> !vco_regulator_on) // R17
		else $error("replace mode failed to force regulator off");

	a_regulator_or: assert property (@(posedge clk) disable iff (!rst_b)
		!regulator_switch_mode && pll_regulator_normal |-> pll_regulator_on) // R17
		else $error("OR mode dropped normal regulator control");

	a_offset_sink_gate: assert property (@(posedge clk) disable iff (!rst_b)
		crystal_offset_sink_select |-> crystal_offset_enable) // R8
		else $error("offset sink active without offset enable");

	a_offset_sink_follow: assert property (@(posedge clk) disable iff (!rst_b)
		crystal_offset_enable |-> crystal_offset_sink_select == regs_q[IDX_XO][`TTRB_B_XO_SINK]) // R8
		else $error("offset sink direction not following its bit");

	a_step_bypass: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr_en && reg_wr_addr == `TTRB_OFS_BLOCK_FORCE_ENABLE |=>
		amp_step_bypass_test == $past(reg_wr_data[0])) // R4
		else $error("step bypass bit not applied");

	a_digital_probe: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr_en && reg_wr_addr == `TTRB_OFS_TEST_SIGNAL_SELECT |=>
		digital_probe_select == $past(reg_wr_data[6:4]) && filter_multitone_enable == $past(reg_wr_data[7])) // R12 R13
		else $error("test signal select not applied");

	// Covers for the main scenarios: an override in use, replace mode, a manual readback.
	c_override_used: cover property (@(posedge clk) disable iff (!rst_b) !crystal_ready_raw && crystal_ready);
	c_replace_mode: cover property (@(posedge clk) disable iff (!rst_b)
		regulator_switch_mode && amp_regulator_normal && !amp_regulator_on);
	c_manual_read: cover property (@(posedge clk) disable iff (!rst_b)
		reg_rd_en && reg_rd_addr == `TTRB_OFS_RC_CAL_CONTROL && cal_bus.suppress);
endmodule : ttrb_test_register_bank

//--- ttrb_test_register_bank_tb.sv
// Purpose: Self-checking bench for the transceiver test register bank.
// Assumes: Registers are reached through the one-cycle write and read strobes.
// Notes: Table rows cover plain writes; overrides, calibration and resets are hand tests.
`timescale 1ns/1ps
`include "ttrb_regs.svh"
module ttrb_test_register_bank_tb;
	import ttrb_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, regulator_switch_mode = 1'b0, rc_cal_done = 1'b0;
	ttrb_byte_t reg_wr_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_addr = 8'h00, reg_rd_data;
	logic [2:0] normal = 3'h0;
	logic [4:0] raw = 5'h00;
	ttrb_cal_val_t rc_cal_auto_value = 4'h0, rc_cal_result;
	logic vco_regulator_on, pll_regulator_on, amp_regulator_on, vco_regulator_ready, pll_regulator_ready;
	logic amp_regulator_ready, pll_lock, crystal_ready, filter_multitone_enable, if_buffer_low_supply;
	logic digital_regulator_disable, oscillator_core_test_enable, vco_block_enable, prescaler_enable;
	logic phase_detector_enable, pll_clock_enable, amp_block_enable, bandgap_enable, receiver_enable;
	logic amp_step_bypass_test, rc_cal_start, rc_cal_busy, crystal_offset_sink_select, crystal_offset_enable;
	logic crystal_startup_kick_disable, crystal_detector_disable, crystal_bias_disable;
	logic [2:0] digital_probe_select, analog_probe_select, crystal_offset_current_level;
	logic [3:0] receive_debug_select;
	logic [1:0] pll_test_config, rc_cal_reference_adjust;
	int error_cnt = 0, num_checks = 0, cyc = 0, cnt_start = 0;
	// Rows hold address, written byte and the byte expected on the output pins.
	logic [23:0] rows [8] = '{24'h35A5A5, 24'h365A5A, 24'h37FFFF, 24'h38AAAA, 24'h385555, 24'h3AF0E0,
		24'h3A1F1F, 24'h350000};

	ttrb_test_register_bank DUT (.clk, .rst_b, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_en,
		.reg_rd_addr, .reg_rd_data, .regulator_switch_mode, .vco_regulator_normal(normal[2]),
		.pll_regulator_normal(normal[1]), .amp_regulator_normal(normal[0]), .vco_regulator_on,
		.pll_regulator_on, .amp_regulator_on, .vco_regulator_ready_raw(raw[4]), .pll_regulator_ready_raw(raw[3]),
		.amp_regulator_ready_raw(raw[2]), .pll_lock_raw(raw[1]), .crystal_ready_raw(raw[0]), .vco_regulator_ready,
		.pll_regulator_ready, .amp_regulator_ready, .pll_lock, .crystal_ready, .filter_multitone_enable,
		.digital_probe_select, .receive_debug_select, .if_buffer_low_supply, .analog_probe_select,
		.digital_regulator_disable, .pll_test_config, .oscillator_core_test_enable, .vco_block_enable,
		.prescaler_enable, .phase_detector_enable, .pll_clock_enable, .amp_block_enable, .bandgap_enable,
		.receiver_enable, .amp_step_bypass_test, .rc_cal_start, .rc_cal_done, .rc_cal_auto_value,
		.rc_cal_reference_adjust, .rc_cal_result, .rc_cal_busy, .crystal_offset_current_level,
		.crystal_offset_sink_select, .crystal_offset_enable, .crystal_startup_kick_disable,
		.crystal_detector_disable, .crystal_bias_disable);

	// ------------------------------------------------------------------
	// Clock, hang guard and start pulse counter
	// ------------------------------------------------------------------
	always #5 clk = ~clk;

	// The run needs about 110 cycles, so a ceiling of 3000 only trips on a hang.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rc_cal_start === 1'b1) cnt_start <= cnt_start + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			end_sim();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input ttrb_byte_t seen, input ttrb_byte_t exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Strobes are dropped at the taking edge, so the next call waits a fresh edge.
	task automatic wr(input ttrb_byte_t a, input ttrb_byte_t d);
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_wr_addr <= a;
		reg_wr_data <= d;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input ttrb_byte_t a, output ttrb_byte_t d);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_rd_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rd_data;
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic chk_cleared;
		ttrb_byte_t d;
		for (int i = 0; i < 6; i++) begin
			rd(8'h35 + 8'(i), d);
			chk(d, 8'h00);
		end
		chk({rc_cal_busy, 3'h0, rc_cal_result}, 8'h00);
	endtask : chk_cleared

	function automatic ttrb_byte_t obs(input ttrb_byte_t a);
		case (a)
			`TTRB_OFS_TEST_SIGNAL_SELECT: obs = {filter_multitone_enable, digital_probe_select, receive_debug_select};
			`TTRB_OFS_ANALOG_TEST: obs = {if_buffer_low_supply, analog_probe_select, digital_regulator_disable,
				pll_test_config, oscillator_core_test_enable};
			`TTRB_OFS_REGULATOR_OVERRIDE: obs = {vco_regulator_on, pll_regulator_on, amp_regulator_on,
				vco_regulator_ready, pll_regulator_ready, amp_regulator_ready, pll_lock, crystal_ready};
			`TTRB_OFS_BLOCK_FORCE_ENABLE: obs = {vco_block_enable, prescaler_enable, phase_detector_enable,
				pll_clock_enable, amp_block_enable, bandgap_enable, receiver_enable, amp_step_bypass_test};
			default: obs = {crystal_offset_current_level, crystal_offset_sink_select, crystal_offset_enable,
				crystal_startup_kick_disable, crystal_detector_disable, crystal_bias_disable};
		endcase
	endfunction : obs

	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		ttrb_byte_t d;
		int n;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		chk_cleared();
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			chk(obs(rows[i][23:16]), rows[i][7:0]);
			rd(rows[i][23:16], d);
			chk(d, rows[i][15:8]);
		end
		$display("test table done");
		// Forced regulators against the normal controls in both switch modes.
		wr(`TTRB_OFS_REGULATOR_OVERRIDE, 8'hA0);
		normal <= 3'b010;
		settle(1);
		chk({5'h00, vco_regulator_on, pll_regulator_on, amp_regulator_on}, 8'h07);
		regulator_switch_mode <= 1'b1;
		normal <= 3'b111;
		settle(1);
		chk({5'h00, vco_regulator_on, pll_regulator_on, amp_regulator_on}, 8'h05);
		regulator_switch_mode <= 1'b0;
		normal <= 3'b000;
		wr(`TTRB_OFS_REGULATOR_OVERRIDE, 8'h00);
		raw <= 5'b10101;
		settle(1);
		chk(obs(`TTRB_OFS_REGULATOR_OVERRIDE), 8'h15);
		wr(`TTRB_OFS_REGULATOR_OVERRIDE, 8'h1F);
		raw <= 5'b00000;
		settle(1);
		chk(obs(`TTRB_OFS_REGULATOR_OVERRIDE), 8'h1F);
		$display("test overrides done");
		wr(8'h40, 8'hFF);
		rd(8'h40, d);
		chk(d, 8'h00);
		rd(8'h34, d);
		chk(d, 8'h00);
		$display("test unmapped done");
		// Every adjust code with suppress held, so no calibration can start meanwhile.
		for (int j = 0; j < 4; j++) begin
			wr(`TTRB_OFS_RC_CAL_CONTROL, {2'b01, 2'(j), 4'h9});
			chk({6'h00, rc_cal_reference_adjust}, 8'(j));
		end
		settle(1);
		chk({4'h0, rc_cal_result}, 8'h09);
		rd(`TTRB_OFS_RC_CAL_CONTROL, d);
		chk(d, 8'h79);
		n = cnt_start;
		wr(`TTRB_OFS_RC_CAL_CONTROL, 8'hC9);
		settle(3);
		chk(8'(cnt_start - n), 8'h00);
		wr(`TTRB_OFS_RC_CAL_CONTROL, 8'h00);
		wr(`TTRB_OFS_RC_CAL_CONTROL, 8'h80);
		settle(2);
		chk({rc_cal_busy, 3'h0, 4'(cnt_start - n)}, 8'h81);
		rc_cal_done <= 1'b1;
		rc_cal_auto_value <= 4'hC;
		@(posedge clk);
		rc_cal_done <= 1'b0;
		settle(2);
		chk({rc_cal_busy, 3'h0, rc_cal_result}, 8'h0C);
		wr(`TTRB_OFS_RC_CAL_CONTROL, 8'h80);
		settle(3);
		chk(8'(cnt_start - n), 8'h01);
		rd(`TTRB_OFS_RC_CAL_CONTROL, d);
		chk(d, 8'h8C);
		$display("test calibration done");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		chk_cleared();
		$display("test second reset done");
		end_sim();
	end
endmodule : ttrb_test_register_bank_tb
